// *** rtl/fcd_decoder.sv ***
/*
  Floppy controller command decoder: collects command bytes from the
  data register, decodes opcode and parameters, sequences command,
  execution and result phases and serves result bytes.
  Assumes the host follows the status handshake; execution-phase data
  movement and drive timing live in neighbouring blocks, fed by the
  decoded outputs and by the status inputs.
*/
// Behaviour
// [RULE_01] Select line low status, high data
// [RULE_02] Host holds select high for data
// [RULE_03] Don't-care command bits are ignored
// [RULE_04] Opcode 01100 starts read-deleted, nine bytes
// [RULE_05] Opcode 0 MF 001101 starts format, six bytes
// [RULE_06] Format returns three status, four ID
// [RULE_07] Opcode 10001 starts scan-equal with stride
// [RULE_08] Scan low/high compare, return status, ID
// [RULE_09] Read-ID returns status then found ID; code returns cylinder 0, head bit, sector 0, size 0 from param_out
// [RULE_10] Read-track reads index through last sector
// [RULE_11] Recalibrate steps selected head to zero
// [RULE_12] Sense interrupt returns status zero, cylinder
// [RULE_13] Sense drive returns one drive byte
// [RULE_14] Seek steps head to target cylinder
// [RULE_15] Invalid opcode returns one byte 80h
// [RULE_16] Cylinder is track index 0..76
// [RULE_17] Short length used only for size 00
// [RULE_18] Transfer ends after last sector number
// [RULE_19] Gap length sets sync-low bytes, gap 3
// [RULE_20] Head bit drives head select output
// [RULE_21] Settle 2..254 ms, release 16..240 ms
// [RULE_22] Density flag picks FM or MFM
// [RULE_23] Multi-track continues sector 1 side 1
// [RULE_24] Step interval 1..16 ms, F is 1
// [RULE_25] No-DMA flag selects non-DMA transfers
// [RULE_26] Skip flag skips deleted-mark sectors
// [RULE_27] Stride 1 consecutive, 2 alternate sectors
// [RULE_28] Count bytes, execute, wait all results
// [RULE_29] Latch every parameter for execution
`timescale 1ns/10ps
`include "fcd_regs.svh"
module fcd_decoder #(
  parameter int EXEC_CYC = `FCD_EXEC_CYC
) (
  input wire logic ref_clk_in,
  input wire logic nrst_in,
  input wire logic register_select_line_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [7:0] wr_data_in,
  input wire fcd_pkg::fcd_status_s status_in,
  output logic [7:0] rd_data_out,
  output logic busy_out,
  output logic dir_out_to_host_out,
  output logic exec_start_out,
  output logic [4:0] opcode_out,
  output fcd_pkg::fcd_param_s param_out,
  output fcd_pkg::fcd_timing_s timing_out,
  output logic head_select_out,
  output logic mfm_out,
  output logic use_short_len_out,
  output logic [7:0] cyl_index_out,
  output logic cyl_range_err_out,
  output logic step_to_zero_out,
  output logic step_to_target_out,
  output logic mt_continue_out,
  output logic [20:0] step_cyc_out,
  output logic [7:0] stride_out
);
  import fcd_pkg::*;
  localparam int CYC_PER_MS = `FCD_CYC_PER_US * `FCD_STEP_UNIT_US;

  fcd_phase_e phase_r, phase_nxt;
  logic [3:0] cnt_r;
  logic [3:0] len_r;
  logic [2:0] rlen_r;
  logic [15:0] exec_cnt_r;
  logic [7:0] res_r [0:6];
  logic [7:0] byte_r [0:8];
  logic [4:0] opcode_r;
  logic invalid_r;

  // Expected command length per opcode; zero marks an invalid opcode
  function automatic logic [3:0] cmd_len(input logic [4:0] op);
    unique case (op)
      `FCD_OP_READ_DATA, `FCD_OP_READ_DEL, `FCD_OP_WRITE_DATA, `FCD_OP_WRITE_DEL,
      `FCD_OP_READ_TRACK, `FCD_OP_SCAN_EQ, `FCD_OP_SCAN_LE, `FCD_OP_SCAN_HE: cmd_len = 4'h9;
      `FCD_OP_FORMAT: cmd_len = 4'h6;
      `FCD_OP_READ_ID, `FCD_OP_RECAL, `FCD_OP_SENSE_DRV: cmd_len = 4'h2;
      `FCD_OP_SEEK, `FCD_OP_SPECIFY: cmd_len = 4'h3;
      `FCD_OP_SENSE_INT: cmd_len = 4'h1;
      default: cmd_len = 4'h0;
    endcase
  endfunction

  // Result length per opcode
  function automatic logic [2:0] res_len(input logic [4:0] op);
    unique case (op)
      `FCD_OP_SENSE_INT: res_len = 3'h2;
      `FCD_OP_SENSE_DRV: res_len = 3'h1;
      `FCD_OP_RECAL, `FCD_OP_SEEK, `FCD_OP_SPECIFY: res_len = 3'h0;
      default: res_len = 3'h7;
    endcase
  endfunction

  // Bits 7..5 are modifiers for some codes; fixed zero for others
  // [RULE_03] modifier masking
  wire [4:0] op_in = wr_data_in[4:0];
  wire mods_ok = (op_in == `FCD_OP_READ_TRACK) ? !wr_data_in[7] :
                 (op_in == `FCD_OP_FORMAT || op_in == `FCD_OP_READ_ID)
                   ? (!wr_data_in[7] && !wr_data_in[5]) :
                 (cmd_len(op_in) == 4'h9) ? 1'b1 : (wr_data_in[7:5] == 3'h0);
  wire [4:0] op_eff = mods_ok ? op_in : 5'h1F;
  // [RULE_01] select line steers data or status
  wire data_wr = wr_in && register_select_line_in;
  wire data_rd = rd_in && register_select_line_in;
  wire [7:0] msr = {phase_r == FCD_CMD || phase_r == FCD_IDLE || phase_r == FCD_RES,
                    phase_r == FCD_RES, phase_r == FCD_EXEC && timing_out.no_dma_flag,
                    phase_r != FCD_IDLE, 4'h0};
  wire cmd_done = (phase_r == FCD_CMD) && data_wr && (cnt_r + 4'h1 == len_r);
  wire exec_done = (phase_r == FCD_EXEC) && (exec_cnt_r == 16'(EXEC_CYC - 1));
  wire res_done = (phase_r == FCD_RES) && data_rd && (cnt_r + 4'h1 == {1'b0, rlen_r});

  // [RULE_28] phase sequencing
  always_comb begin
    phase_nxt = phase_r;
    unique case (phase_r)
      FCD_IDLE: begin
        if (data_wr) begin
          phase_nxt = (cmd_len(op_eff) == 4'h1) ? FCD_EXEC :
                      (cmd_len(op_eff) == 4'h0) ? FCD_RES : FCD_CMD;
        end
      end
      FCD_CMD: if (cmd_done) phase_nxt = FCD_EXEC;
      FCD_EXEC: if (exec_done) phase_nxt = (rlen_r == 3'h0) ? FCD_IDLE : FCD_RES;
      FCD_RES: if (res_done) phase_nxt = FCD_IDLE;
    endcase
  end

  // Phase and byte counters
  always_ff @(posedge ref_clk_in) begin
    if (!nrst_in) begin
      phase_r <= FCD_IDLE;
      cnt_r <= 4'h0;
      len_r <= 4'h0;
      rlen_r <= 3'h0;
      opcode_r <= 5'h00;
      invalid_r <= 1'b0;
      exec_cnt_r <= 16'h0000;
    end else begin
      phase_r <= phase_nxt;
      exec_cnt_r <= (phase_r == FCD_EXEC) ? exec_cnt_r + 16'h0001 : 16'h0000;
      if (phase_r == FCD_IDLE && data_wr) begin
        opcode_r <= op_eff;
        len_r <= cmd_len(op_eff);
        // [RULE_15] invalid gives one result byte
        invalid_r <= (cmd_len(op_eff) == 4'h0);
        rlen_r <= (cmd_len(op_eff) == 4'h0) ? 3'h1 : res_len(op_eff);
        cnt_r <= (cmd_len(op_eff) == 4'h0) ? 4'h0 : 4'h1;
      end else if (cmd_done || exec_done || res_done) begin
        cnt_r <= 4'h0;
      end else if ((phase_r == FCD_CMD && data_wr) || (phase_r == FCD_RES && data_rd)) begin
        cnt_r <= cnt_r + 4'h1;
      end
    end
  end

  // [RULE_29] parameter holding registers
  always_ff @(posedge ref_clk_in) begin
    if (!nrst_in) begin
      for (int i = 0; i < 9; i++) byte_r[i] <= 8'h00;
    end else if (data_wr && (phase_r == FCD_IDLE || phase_r == FCD_CMD)) begin
      byte_r[phase_r == FCD_IDLE ? 4'h0 : cnt_r] <= wr_data_in;
    end
  end

  // Result bytes captured at the end of execution, or at the opcode write for an invalid opcode
  // [RULE_06] [RULE_09] status then ID bytes
  always_ff @(posedge ref_clk_in) begin
    if (!nrst_in) begin
      for (int i = 0; i < 7; i++) res_r[i] <= 8'h00;
    end else if (phase_r == FCD_IDLE && data_wr && cmd_len(op_eff) == 4'h0) begin
      res_r[0] <= `FCD_ST0_INVALID;
    end else if (exec_done) begin
      // [RULE_12] [RULE_13] sense results
      res_r[0] <= (opcode_r == `FCD_OP_SENSE_DRV) ? status_in.drive_state_byte
                                                   : status_in.status_byte_zero;
      res_r[1] <= (opcode_r == `FCD_OP_SENSE_INT) ? status_in.current_cylinder
                                                   : status_in.status_byte_one;
      res_r[2] <= status_in.status_byte_two;
      res_r[3] <= param_out.cyl;
      res_r[4] <= param_out.head;
      res_r[5] <= param_out.sector;
      res_r[6] <= param_out.size_code;
    end
  end

  // Decoded parameter views per opcode
  // [RULE_04] [RULE_07] [RULE_08] field layout of long commands
  wire long_cmd = (len_r == 4'h9);
  wire fmt_cmd = (opcode_r == `FCD_OP_FORMAT);
  wire seek_cmd = (opcode_r == `FCD_OP_SEEK);
  wire scan_cmd = (opcode_r == `FCD_OP_SCAN_EQ) || (opcode_r == `FCD_OP_SCAN_LE)
                  || (opcode_r == `FCD_OP_SCAN_HE);
  fcd_param_s par_w;
  assign par_w.multi_track_flag = byte_r[0][`FCD_BIT_MT];
  assign par_w.double_density_select = byte_r[0][`FCD_BIT_MF];
  assign par_w.ignore_deleted_marks = byte_r[0][`FCD_BIT_SK];
  assign par_w.head_select_bit = byte_r[1][`FCD_BIT_HD];
  assign par_w.drive_select_hi = byte_r[1][1];
  assign par_w.drive_select_lo = byte_r[1][0];
  // [RULE_05] format layout: size, sectors, gap 3, fill
  assign par_w.cyl = long_cmd ? byte_r[2] : 8'h00;
  assign par_w.head = long_cmd ? byte_r[3] : {7'h00, byte_r[1][`FCD_BIT_HD]};
  assign par_w.sector = long_cmd ? byte_r[4] : 8'h00;
  assign par_w.size_code = long_cmd ? byte_r[5] : (fmt_cmd ? byte_r[2] : 8'h00);
  // [RULE_10] [RULE_18] last sector stops transfer
  assign par_w.last_sector_number = long_cmd ? byte_r[6] : (fmt_cmd ? byte_r[3] : 8'h00);
  // [RULE_19] gap length for sync and gap 3
  assign par_w.gap3_length = long_cmd ? byte_r[7] : (fmt_cmd ? byte_r[4] : 8'h00);
  assign par_w.short_record_length = (long_cmd && !scan_cmd) ? byte_r[8]
                                     : (fmt_cmd ? byte_r[5] : 8'h00);
  assign par_w.scan_sector_stride = scan_cmd ? byte_r[8] : 8'h00;
  assign par_w.target_cylinder = seek_cmd ? byte_r[2] : 8'h00;

  // Registered outputs, refreshed once command bytes are complete
  always_ff @(posedge ref_clk_in) begin
    if (!nrst_in) begin
      param_out <= '0;
      timing_out <= '0;
      opcode_out <= 5'h00;
      exec_start_out <= 1'b0;
      head_select_out <= 1'b0;
      mfm_out <= 1'b0;
      use_short_len_out <= 1'b0;
      cyl_index_out <= 8'h00;
      cyl_range_err_out <= 1'b0;
      step_to_zero_out <= 1'b0;
      step_to_target_out <= 1'b0;
      mt_continue_out <= 1'b0;
      step_cyc_out <= 21'h00000;
      stride_out <= 8'h00;
    end else begin
      exec_start_out <= (phase_nxt == FCD_EXEC) && (phase_r != FCD_EXEC);
      step_to_zero_out <= 1'b0;
      step_to_target_out <= 1'b0;
      if (phase_r == FCD_EXEC && exec_cnt_r == 16'h0000) begin
        param_out <= par_w;
        opcode_out <= opcode_r;
        // [RULE_20] head bit to pin
        head_select_out <= par_w.head_select_bit;
        // [RULE_22] density select
        mfm_out <= par_w.double_density_select;
        // [RULE_17] short length only for size 00
        use_short_len_out <= (par_w.size_code == `FCD_SIZE_SHORT) && long_cmd;
        // [RULE_16] cylinder index range
        cyl_index_out <= seek_cmd ? par_w.target_cylinder : par_w.cyl;
        cyl_range_err_out <= (seek_cmd ? par_w.target_cylinder : par_w.cyl) > `FCD_MAX_CYL;
        // [RULE_11] recalibrate to track zero
        step_to_zero_out <= (opcode_r == `FCD_OP_RECAL);
        // [RULE_14] seek to target
        step_to_target_out <= seek_cmd;
        // [RULE_23] multi-track continuation
        mt_continue_out <= long_cmd && par_w.multi_track_flag && !par_w.head_select_bit;
        // [RULE_27] stride passed to scan engine
        stride_out <= par_w.scan_sector_stride;
        // [RULE_26] skip flag travels in param_out
        if (opcode_r == `FCD_OP_SPECIFY) begin
          // [RULE_21] [RULE_25] settle, release, no-DMA
          timing_out.step_interval <= byte_r[1][7:4];
          timing_out.head_release_delay <= byte_r[1][3:0];
          timing_out.head_settle_time <= byte_r[2][7:1];
          timing_out.no_dma_flag <= byte_r[2][`FCD_BIT_ND];
          // [RULE_24] F is 1 ms, E is 2 ms
          // Code 0 means 16 ms, so the count needs 21 bits at 100 MHz
          step_cyc_out <= 21'((5'h10 - {1'b0, byte_r[1][7:4]}) * CYC_PER_MS);
        end
      end
    end
  end

  // Host-facing read data and status bits
  always_ff @(posedge ref_clk_in) begin
    if (!nrst_in) begin
      rd_data_out <= 8'h00;
      busy_out <= 1'b0;
      dir_out_to_host_out <= 1'b0;
    end else begin
      busy_out <= (phase_nxt != FCD_IDLE);
      dir_out_to_host_out <= (phase_nxt == FCD_RES);
      rd_data_out <= register_select_line_in ? res_r[3'(cnt_r)] : msr;
    end
  end

  // Invalid opcode result holds the fixed byte
  a_invalid_result: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    (phase_r == FCD_RES && invalid_r) |-> res_r[0] == `FCD_ST0_INVALID) // [RULE_15]
    else $error("invalid opcode result not 80h");
  a_cmd_to_exec: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    cmd_done |=> phase_r == FCD_EXEC) // [RULE_28]
    else $error("execution did not follow last byte");
  a_no_new_cmd: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    (phase_r == FCD_RES && !res_done) |=> phase_r == FCD_RES) // [RULE_28]
    else $error("result phase left early");
  a_exec_start: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    cmd_done |=> exec_start_out) // [RULE_28]
    else $error("execution start pulse missing");
  a_hold_params: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    (phase_r == FCD_EXEC && exec_cnt_r != 16'h0000) |=> $stable(param_out)) // [RULE_29]
    else $error("parameters changed during execution");
  a_head_pin: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    (phase_r == FCD_EXEC && exec_cnt_r == 16'h0001) |-> head_select_out == param_out.head_select_bit) // [RULE_20]
    else $error("head select pin mismatch");
  a_density_out: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    (phase_r == FCD_EXEC && exec_cnt_r == 16'h0001) |-> mfm_out == param_out.double_density_select) // [RULE_22]
    else $error("density output mismatch");
  a_short_len: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    use_short_len_out |-> param_out.size_code == `FCD_SIZE_SHORT) // [RULE_17]
    else $error("short length used with nonzero size");
  a_status_read: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    (rd_in && !register_select_line_in) |=> rd_data_out == $past(msr)) // [RULE_01]
    else $error("status register not returned");
  // [RULE_15] invalid opcode skips execution
  sequence s_bad_opcode;
    phase_r == FCD_IDLE && data_wr && cmd_len(op_eff) == 4'h0;
  endsequence
  sequence s_straight_to_result;
    phase_r == FCD_RES && dir_out_to_host_out && !exec_start_out;
  endsequence
  a_invalid_no_exec: assert property (@(posedge ref_clk_in) disable iff (!nrst_in)
    s_bad_opcode |=> s_straight_to_result) // [RULE_15]
    else $error("invalid opcode started execution");
endmodule

// *** shared/fcd_regs.svh ***
/*
  Constants of the floppy command decoder: opcodes, clock rate,
  field positions, fixed result and limit values and timing counts.
  Assumes a 100 MHz controller clock.
*/
`ifndef FCD_REGS_SVH
`define FCD_REGS_SVH
`define FCD_OP_READ_DATA 5'h06
`define FCD_OP_READ_DEL 5'h0C
`define FCD_OP_WRITE_DATA 5'h05
`define FCD_OP_WRITE_DEL 5'h09
`define FCD_OP_READ_TRACK 5'h02
`define FCD_OP_READ_ID 5'h0A
`define FCD_OP_FORMAT 5'h0D
`define FCD_OP_SCAN_EQ 5'h11
`define FCD_OP_SCAN_LE 5'h19
`define FCD_OP_SCAN_HE 5'h1D
`define FCD_OP_RECAL 5'h07
`define FCD_OP_SENSE_INT 5'h08
`define FCD_OP_SPECIFY 5'h03
`define FCD_OP_SENSE_DRV 5'h04
`define FCD_OP_SEEK 5'h0F
`define FCD_BIT_MT 7
`define FCD_BIT_MF 6
`define FCD_BIT_SK 5
`define FCD_BIT_HD 2
`define FCD_BIT_ND 0
`define FCD_ST0_INVALID 8'h80
`define FCD_MAX_CYL 8'h4C
`define FCD_SIZE_SHORT 8'h00
`define FCD_CLK_MHZ 100
`define FCD_STEP_UNIT_US 1000
`define FCD_SETTLE_UNIT_US 2000
`define FCD_RELEASE_UNIT_US 16000
`define FCD_CYC_PER_US 100
`define FCD_EXEC_CYC 16
`endif

// *** shared/fcd_pkg.sv ***
/*
  Types of the floppy command decoder.
  Assumes fcd_regs.svh provides all numbers.
*/
package fcd_pkg;
  typedef enum logic [2:0] {
    FCD_IDLE = 3'b000,
    FCD_CMD = 3'b001,
    FCD_EXEC = 3'b011,
    FCD_RES = 3'b010
  } fcd_phase_e;
  typedef struct packed {
    logic multi_track_flag;
    logic double_density_select;
    logic ignore_deleted_marks;
    logic head_select_bit;
    logic drive_select_hi;
    logic drive_select_lo;
    logic [7:0] cyl;
    logic [7:0] head;
    logic [7:0] sector;
    logic [7:0] size_code;
    logic [7:0] last_sector_number;
    logic [7:0] gap3_length;
    logic [7:0] short_record_length;
    logic [7:0] scan_sector_stride;
    logic [7:0] target_cylinder;
  } fcd_param_s;
  typedef struct packed {
    logic [3:0] step_interval;
    logic [3:0] head_release_delay;
    logic [6:0] head_settle_time;
    logic no_dma_flag;
  } fcd_timing_s;
  typedef struct packed {
    logic [7:0] status_byte_zero;
    logic [7:0] status_byte_one;
    logic [7:0] status_byte_two;
    logic [7:0] drive_state_byte;
    logic [7:0] current_cylinder;
  } fcd_status_s;
endpackage

// *** sim/fcd_host_model.sv ***
/*
  Host processor model for the command decoder: writes command bytes,
  reads result bytes and can make stray status-register strobes.
  Assumes the caller runs it off the falling edge of ref_clk_in.
*/
`timescale 1ns/10ps
module fcd_host_model (
  input wire logic ref_clk_in,
  input wire logic [7:0] rd_data_in,
  output logic register_select_line_out,
  output logic wr_out,
  output logic rd_out,
  output logic [7:0] wr_data_out
);
  // Quiet bus at time zero
  initial begin
    register_select_line_out = 1'b0;
    wr_out = 1'b0;
    rd_out = 1'b0;
    wr_data_out = 8'h00;
  end
  task automatic put(input logic [7:0] b);
    @(negedge ref_clk_in);
    register_select_line_out = 1'b1;
    rd_out = 1'b0;
    wr_out = 1'b1;
    wr_data_out = b;
  endtask
  // Strobe aimed at the status register on purpose
  task automatic stray(input logic [7:0] b);
    @(negedge ref_clk_in);
    register_select_line_out = 1'b0;
    wr_out = 1'b1;
    wr_data_out = b;
  endtask
  // Released data flips so a stale byte never passes for a fresh one
  task automatic idle();
    @(negedge ref_clk_in);
    wr_out = 1'b0;
    rd_out = 1'b0;
    wr_data_out = ~wr_data_out;
  endtask
  task automatic get(output logic [7:0] b);
    @(negedge ref_clk_in);
    register_select_line_out = 1'b1;
    wr_out = 1'b0;
    rd_out = 1'b1;
    @(negedge ref_clk_in);
    rd_out = 1'b0;
    b = rd_data_in;
  endtask
  // Status register read, select low
  task automatic look(output logic [7:0] b);
    @(negedge ref_clk_in);
    register_select_line_out = 1'b0;
    wr_out = 1'b0;
    rd_out = 1'b1;
    @(negedge ref_clk_in);
    rd_out = 1'b0;
    b = rd_data_in;
  endtask
endmodule

// *** sim/fcd_decoder_bench.sv ***
/*
  Self-checking bench for the command decoder: one task per scenario.
  Assumes the host model drives the data register side and this bench
  stands in for the execution logic on status_in.
*/
`timescale 1ns/10ps
`include "fcd_regs.svh"
module fcd_decoder_bench;
  import fcd_pkg::*;
  localparam int EXEC_N = 4;
  logic ref_clk_in, nrst_in, sel, wr, rd, busy, dir, exec_start, hsel, mfm;
  logic short_len, range_err, to_zero, to_target, mt_cont;
  logic [7:0] wr_data, rd_data, cyl_index, stride;
  logic [4:0] opcode;
  logic [20:0] step_cyc;
  fcd_status_s status;
  fcd_param_s param;
  fcd_timing_s timing;
  logic [7:0] res [0:7];
  logic [7:0] ops [0:2] = '{8'h91, 8'h19, 8'h1D};
  int num_errors, checked, cycles, starts, zeros, targets;

  fcd_decoder #(.EXEC_CYC(EXEC_N)) fcd_decoder_i (.ref_clk_in(ref_clk_in), .nrst_in(nrst_in),
    .register_select_line_in(sel), .wr_in(wr), .rd_in(rd), .wr_data_in(wr_data),
    .status_in(status), .rd_data_out(rd_data), .busy_out(busy), .dir_out_to_host_out(dir),
    .exec_start_out(exec_start), .opcode_out(opcode), .param_out(param),
    .timing_out(timing), .head_select_out(hsel), .mfm_out(mfm),
    .use_short_len_out(short_len), .cyl_index_out(cyl_index), .cyl_range_err_out(range_err),
    .step_to_zero_out(to_zero), .step_to_target_out(to_target), .mt_continue_out(mt_cont),
    .step_cyc_out(step_cyc), .stride_out(stride));
  fcd_host_model fcd_host_model_i (.ref_clk_in(ref_clk_in), .rd_data_in(rd_data),
    .register_select_line_out(sel), .wr_out(wr), .rd_out(rd), .wr_data_out(wr_data));

  // Clock at 100 MHz
  initial begin
    ref_clk_in = 1'b0;
    forever #5 ref_clk_in = ~ref_clk_in;
  end
  // Pulse counters and hang guard; tests need only a few hundred cycles
  // Sampled on the falling edge, where registered outputs have settled
  always @(negedge ref_clk_in) begin
    cycles++;
    if (exec_start === 1'b1) starts++;
    if (to_zero === 1'b1) zeros++;
    if (to_target === 1'b1) targets++;
    if (cycles == 20000) begin
      num_errors++;
      final_report();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  // Send bytes, wait out execution, drain every result, expect idle
  task automatic run_cmd(input logic [7:0] b[$], input int nres, input int nexec);
    int n;
    int s0;
    s0 = starts;
    n = 0;
    foreach (b[i]) fcd_host_model_i.put(b[i]);
    fcd_host_model_i.idle();
    while (n < 60 && ((nres > 0) ? dir !== 1'b1 : busy !== 1'b0)) begin
      @(negedge ref_clk_in);
      n++;
    end
    chk("exec start count", nexec, starts - s0);
    for (int k = 0; k < nres; k++) fcd_host_model_i.get(res[k]);
    @(negedge ref_clk_in);
    chk("busy after results", 1'b0, busy);
  endtask

  task automatic t_invalid();
    fcd_host_model_i.stray(8'h08);
    fcd_host_model_i.idle();
    @(negedge ref_clk_in);
    chk("busy after status strobe", 1'b0, busy);
    fcd_host_model_i.look(res[0]);
    chk("idle status register", 8'h80, res[0]);
    run_cmd('{8'h1F}, 1, 0);
    chk("invalid result", `FCD_ST0_INVALID, res[0]);
    run_cmd('{8'hE7}, 1, 0);
    chk("fixed bits result", `FCD_ST0_INVALID, res[0]);
    $display("test invalid done");
  endtask
  task automatic t_sense();
    run_cmd('{8'h08}, 2, 1);
    chk("sense status zero", 8'h21, res[0]);
    chk("sense cylinder", 8'h35, res[1]);
    status.drive_state_byte = 8'h6C;
    run_cmd('{8'h04, 8'h05}, 1, 1);
    chk("drive state", 8'h6C, res[0]);
    chk("head select", 1'b1, hsel);
    $display("test sense done");
  endtask
  task automatic t_timing();
    run_cmd('{8'h03, 8'hE5, 8'h0B}, 0, 1);
    chk("timing fields", {4'hE, 4'h5, 7'h05, 1'b1}, timing);
    chk("step cycles 2ms", 21'd200000, step_cyc);
    run_cmd('{8'h03, 8'hF1, 8'h02}, 0, 1);
    chk("no dma off", 1'b0, timing.no_dma_flag);
    chk("step cycles 1ms", 21'd100000, step_cyc);
    run_cmd('{8'h03, 8'h01, 8'h02}, 0, 1);
    chk("step cycles 16ms", 21'd1600000, step_cyc);
    $display("test timing done");
  endtask
  task automatic t_move();
    int z0;
    int t0;
    z0 = zeros;
    t0 = targets;
    run_cmd('{8'h07, 8'h01}, 0, 1);
    chk("step to zero", 1, zeros - z0);
    run_cmd('{8'h0F, 8'h04, 8'd76}, 0, 1);
    chk("step to target", 1, targets - t0);
    chk("target cylinder", 8'd76, param.target_cylinder);
    chk("seek in range", {8'd76, 1'b0}, {cyl_index, range_err});
    $display("test move done");
  endtask
  task automatic t_rw();
    logic [7:0] exp7 [0:6] = '{8'h21, 8'h41, 8'h82, 8'd77, 8'h01, 8'h03, 8'h00};
    run_cmd('{8'hEC, 8'h04, 8'd77, 8'h01, 8'h03, 8'h00, 8'h09, 8'h1B, 8'h80}, 7, 1);
    chk("opcode", `FCD_OP_READ_DEL, opcode);
    for (int k = 0; k < 7; k++) chk("result byte", exp7[k], res[k]);
    chk("skip and track flags", 2'b11,
        {param.multi_track_flag, param.ignore_deleted_marks});
    chk("density", 1'b1, mfm);
    chk("short length", 1'b1, short_len);
    chk("cylinder range", {8'd77, 1'b1}, {cyl_index, range_err});
    chk("last sector", 8'h09, param.last_sector_number);
    chk("gap and length", {8'h1B, 8'h80},
        {param.gap3_length, param.short_record_length});
    run_cmd('{8'h0D, 8'h00, 8'h02, 8'h09, 8'h54, 8'hE5}, 7, 1);
    chk("format opcode", `FCD_OP_FORMAT, opcode);
    chk("format status", 24'h214182, {res[0], res[1], res[2]});
    chk("fm and long size", 2'b00, {mfm, short_len});
    run_cmd('{8'h4A, 8'h00}, 7, 1);
    chk("read id opcode", `FCD_OP_READ_ID, opcode);
    chk("read id status", 8'h21, res[0]);
    run_cmd('{8'h42, 8'h00, 8'h01, 8'h00, 8'h01, 8'h02, 8'h05, 8'h1B, 8'hFF}, 7, 1);
    chk("track opcode", `FCD_OP_READ_TRACK, opcode);
    chk("track end", 8'h05, param.last_sector_number);
    $display("test read write done");
  endtask
  task automatic t_scan();
    for (int k = 0; k < 3; k++) begin
      run_cmd('{ops[k], 8'hF8, 8'h02, 8'h00, 8'h01, 8'h01, 8'h0F, 8'h1B, 8'(k % 2 + 1)}, 7, 1);
      chk("scan opcode", ops[k][4:0], opcode);
      chk("stride", k % 2 + 1, stride);
      chk("ignored bits", 1'b0, hsel);
      chk("scan cylinder", 8'h02, res[3]);
      chk("multi track continue", (k == 0), mt_cont);
    end
    $display("test scan done");
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Reset, then scenarios in turn
  initial begin
    nrst_in = 1'b0;
    status = {8'h21, 8'h41, 8'h82, 8'h2C, 8'h35};
    repeat (8) @(negedge ref_clk_in);
    nrst_in = 1'b1;
    t_invalid();
    t_sense();
    t_timing();
    t_move();
    t_rw();
    t_scan();
    final_report();
  end
endmodule
